// ### nlk_pkg.sv
// Package for the nonvolatile lock, page map and clock divider block
package nlk_pkg;
  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] ADDR_CLOCK_RATIO = 8'h00;
  localparam logic [7:0] ADDR_CONFIG      = 8'h04;
  localparam logic [7:0] ADDR_OPTION      = 8'h08;
  localparam logic [7:0] ADDR_PROTECTION  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;
  // Field positions
  localparam int RATIO_LOADED_POS = 7;
  localparam int PRESCALE_POS     = 6;
  localparam int HALF_SELECT_POS  = 6;
  localparam int COMPARE_MODE_POS = 5;
  localparam int BACKDOOR_POS     = 7;
  localparam int LAYOUT_POS       = 5;
  // Lock code values and field
  localparam logic [1:0] LOCK_OPEN = 2'h2;
  localparam int KEY_BYTES = 8;
  localparam logic [15:0] KEY_BASE = 16'hffb0;
  localparam int PRESCALE_DIV = 8;
  // Vector block that holds option, protection and key
  localparam logic [15:0] VECTOR_BLOCK_BASE = 16'hfd00;
  // Time per program/erase pulse, in ns
  localparam int PULSE_MIN_NS = 5000;
  localparam int PULSE_MAX_NS = 6700;
  // Access source kinds
  typedef enum logic [1:0] {SRC_SECURE = 2'h0, SRC_UNSECURE = 2'h1, SRC_DEBUG = 2'h2} nlk_src_t;
  // One memory access request from the core side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        is_secure_mem;
    nlk_src_t    src;
  } nlk_acc_t;
  // Gated access result
  typedef struct packed {
    logic       allow;
    logic [7:0] rdata;
  } nlk_gate_t;
endpackage

// ### nlk_top.sv
// Lock gate, backdoor compare, EEPROM page map and nonvolatile clock divider
// Operation
// - Locked: unsecure or debug access blocked, reads zero
// - Code from protected memory always has access
// - Reset copies option byte into working register
// - Lock code 1:0 open, others locked
// - Locked: no debug module, background only by pin
// - Backdoor disabled when allow bit zero
// - Compare mode captures key writes as values
// - Leaving compare mode with match opens lock
// - Key writes only from protected memory
// - Protection register writable only by debug
// - Blank check of whole flash opens lock
// - Option, protection, key share vector block
// - Only foreground EEPROM half is visible
// - Split layout: four bytes per page, erase both
// - Whole layout: sector in one page, erase foreground
// - Ratio bit 7 read-only, low bits write once
// - Reset clears loaded flag; unloaded blocks program/erase
// - Clock is bus, divided eight optionally, then ratio+1
// - Each pulse is one nonvolatile clock cycle
// - Option: allow bit 7, layout bit 5, lock 1:0
// - Config: half select bit 6, compare mode bit 5
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module nlk_top #(
  parameter int CLK_NS = 50
) (
  input  wire logic              CLK_SYS,         // Bus clock, 20 MHz
  input  wire logic              RST,             // Async reset, active high
  input  wire logic              HSEL,            // Slave select
  input  wire logic [7:0]        HADDR,           // Byte address
  input  wire logic [1:0]        HTRANS,          // Transfer type
  input  wire logic              HWRITE,          // Write
  input  wire logic [2:0]        HSIZE,           // Size
  input  wire logic [31:0]       HWDATA,          // Write data
  input  wire logic              HREADY,          // Bus ready in
  output logic [31:0]            HRDATA,          // Read data
  output logic                   HREADYOUT,       // Ready out
  output logic                   HRESP,           // Response
  input  wire logic [7:0]        OPT_BYTE,        // Stored option byte
  input  wire logic [7:0]        PROT_BYTE,       // Stored protection byte
  input  wire logic [63:0]       KEY_PHRASE,      // Stored unlock phrase
  input  wire logic              BACKGROUND_PIN_PIN,        // Background pin
  input  wire nlk_pkg::nlk_acc_t ACC,             // Memory access request
  input  wire logic [7:0]        MEM_RDATA,       // Memory read data
  input  wire logic              BLANK_OK,        // Whole flash blank pulse
  input  wire logic              ERASE_REQ,       // EEPROM sector erase pulse
  output nlk_pkg::nlk_gate_t     GATE,            // Access permit and data
  output logic                   EE_PAGE,         // EEPROM page for access
  output logic [1:0]             EE_ERASE_PAGES,  // Pages cleared by erase
  output logic                   KEY_CAPTURE,     // Key write captured
  output logic                   CMD_START,       // Write starts command
  output logic                   LOCKED,          // Lock state
  output logic                   DEBUG_ENABLE_OK, // Debug module allowed
  output logic                   BGND_ACTIVE,     // Active background mode
  output logic                   PE_ENABLE,       // Program/erase allowed
  output logic                   NVM_PULSE        // One nonvolatile clock pulse
);
  import nlk_pkg::*;

  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;

  logic [7:0]  working_option_reg;
  logic [7:0]  protection_reg;
  logic [7:0]  nvm_config_reg;
  logic [7:0]  nvm_clock_ratio;
  logic        opened;
  logic        opt_taken;
  logic [63:0] key_buf;
  logic [3:0]  key_cnt;
  logic        key_dirty;
  logic        bk_s1;
  logic        bk_s2;
  logic        bgnd_seen;
  logic [1:0]  lock_state_code;
  logic        backdoor_allow;
  logic        eeprom_sector_layout;
  logic        compare_write_mode;
  logic        eeprom_half_select;
  logic        ratio_loaded_flag;
  logic        prescale_by_eight;
  logic [5:0]  ratio_div;
  logic        is_key_addr;
  logic        acc_ok;

  // Option fields and lock decode
  assign lock_state_code      = opened ? LOCK_OPEN : working_option_reg[1:0];
  assign backdoor_allow       = working_option_reg[BACKDOOR_POS];
  assign eeprom_sector_layout = working_option_reg[LAYOUT_POS];
  assign compare_write_mode   = nvm_config_reg[COMPARE_MODE_POS];
  assign eeprom_half_select   = nvm_config_reg[HALF_SELECT_POS];
  assign ratio_loaded_flag    = nvm_clock_ratio[RATIO_LOADED_POS];
  assign prescale_by_eight    = nvm_clock_ratio[PRESCALE_POS];
  assign ratio_div            = nvm_clock_ratio[5:0];
  assign LOCKED               = (lock_state_code != LOCK_OPEN);

  // AHB-Lite address phase capture
  logic       ph_wr;
  logic       ph_rd;
  logic [7:0] ph_addr;
  logic       take;
  assign take = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 8'h00;
    end
    else if (HREADY)
    begin
      ph_wr   <= take && HWRITE;
      ph_rd   <= take && !HWRITE;
      ph_addr <= HADDR;
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Read data, zero for unmapped
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      HRDATA <= 32'h0000_0000;
    else if (take && !HWRITE)
    begin
      if (HADDR == ADDR_CLOCK_RATIO)
        HRDATA <= {24'h000000, nvm_clock_ratio};
      else if (HADDR == ADDR_CONFIG)
        HRDATA <= {24'h000000, nvm_config_reg};
      else if (HADDR == ADDR_OPTION)
        HRDATA <= {24'h000000, working_option_reg[7:2], lock_state_code};
      else if (HADDR == ADDR_PROTECTION)
        HRDATA <= {24'h000000, protection_reg};
      else if (HADDR == ADDR_STATUS)
        HRDATA <= {28'h0000000, key_cnt};
      else
        HRDATA <= 32'h0000_0000;
    end
  end

  // Option and protection copy taken at reset release
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      opt_taken          <= 1'b0;
      working_option_reg <= 8'hff;
      protection_reg     <= 8'hff;
    end
    else if (!opt_taken)
    begin
      opt_taken          <= 1'b1;
      working_option_reg <= OPT_BYTE;
      protection_reg     <= PROT_BYTE;
    end
    else if (ph_wr && ph_addr == ADDR_PROTECTION && ACC.src == SRC_DEBUG)
      protection_reg <= HWDATA[7:0];
  end

  // Configuration register, software writable
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      nvm_config_reg <= 8'h00;
    else if (ph_wr && ph_addr == ADDR_CONFIG)
      nvm_config_reg <= {1'b0, HWDATA[HALF_SELECT_POS], HWDATA[COMPARE_MODE_POS], 5'h00};
  end

  // Clock ratio, write once; first write sets loaded flag
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      nvm_clock_ratio <= 8'h00;
    else if (ph_wr && ph_addr == ADDR_CLOCK_RATIO && !ratio_loaded_flag)
      nvm_clock_ratio <= {1'b1, HWDATA[6:0]};
  end
  assign PE_ENABLE = ratio_loaded_flag;

  // Key address decode and access gating
  assign is_key_addr = (ACC.addr >= KEY_BASE) && (ACC.addr < KEY_BASE + 16'(KEY_BYTES));
  assign acc_ok = !LOCKED || (ACC.src == SRC_SECURE);
  always_comb
  begin
    GATE.allow  = ACC.valid && acc_ok;
    GATE.rdata  = (ACC.valid && acc_ok && !ACC.write) ? MEM_RDATA : 8'h00;
    KEY_CAPTURE = ACC.valid && ACC.write && is_key_addr && compare_write_mode
                  && backdoor_allow && ACC.src == SRC_SECURE && ACC.is_secure_mem;
    CMD_START   = ACC.valid && ACC.write && acc_ok && ratio_loaded_flag
                  && !(is_key_addr && compare_write_mode);
  end

  // Key capture by address offset in any order, compare on mode exit
  logic cmp_prev;
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      key_buf   <= 64'h0;
      key_cnt   <= 4'h0;
      key_dirty <= 1'b0;
      cmp_prev  <= 1'b0;
    end
    else
    begin
      cmp_prev <= compare_write_mode;
      if (KEY_CAPTURE)
      begin
        key_buf[8*ACC.addr[2:0] +: 8] <= ACC.wdata;
        key_cnt   <= key_cnt + 4'h1;
        key_dirty <= 1'b1;
      end
      else if (cmp_prev && !compare_write_mode)
      begin
        key_cnt   <= 4'h0;
        key_dirty <= 1'b0;
      end
    end
  end

  // Lock opening, held until reset
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      opened <= 1'b0;
    else if (BLANK_OK)
      opened <= 1'b1;
    else if (cmp_prev && !compare_write_mode && key_dirty && backdoor_allow
             && key_cnt == 4'(KEY_BYTES) && key_buf == KEY_PHRASE)
      opened <= 1'b1;
  end

  // Pin synchroniser runs through reset so the level is ready at release
  always_ff @(posedge CLK_SYS)
  begin
    bk_s1 <= BACKGROUND_PIN_PIN;
    bk_s2 <= bk_s1;
  end
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      bgnd_seen <= 1'b0;
    else if (!opt_taken)
      bgnd_seen <= !bk_s2;
  end
  assign DEBUG_ENABLE_OK = !LOCKED;
  assign BGND_ACTIVE     = bgnd_seen;

  // EEPROM page map and erase extent
  assign EE_PAGE        = eeprom_half_select;
  assign EE_ERASE_PAGES = !ERASE_REQ ? 2'b00 :
                          (!eeprom_sector_layout ? 2'b11 :
                           (eeprom_half_select ? 2'b10 : 2'b01));

  // Nonvolatile clock divider
  logic [2:0] pre_cnt;
  logic [5:0] div_cnt;
  logic       pre_tick;
  assign pre_tick = !prescale_by_eight || (pre_cnt == 3'(PRESCALE_DIV - 1));
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      pre_cnt   <= 3'h0;
      div_cnt   <= 6'h00;
      NVM_PULSE <= 1'b0;
    end
    else if (!ratio_loaded_flag)
    begin
      pre_cnt   <= 3'h0;
      div_cnt   <= 6'h00;
      NVM_PULSE <= 1'b0;
    end
    else
    begin
      NVM_PULSE <= 1'b0;
      pre_cnt   <= prescale_by_eight ? pre_cnt + 3'h1 : 3'h0;
      if (pre_tick)
      begin
        if (div_cnt >= ratio_div)
        begin
          div_cnt   <= 6'h00;
          NVM_PULSE <= 1'b1;
        end
        else
          div_cnt <= div_cnt + 6'h01;
      end
    end
  end

  // Checks
  chk_locked_reads_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    (ACC.valid && LOCKED && ACC.src != SRC_SECURE) |-> (!GATE.allow && GATE.rdata == 8'h00))
    else $error("locked access not blocked");
  chk_secure_access: assert property (@(posedge CLK_SYS) disable iff (RST)
    (ACC.valid && ACC.src == SRC_SECURE) |-> GATE.allow)
    else $error("secure access refused");
  chk_option_copy: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(opt_taken) |-> working_option_reg == $past(OPT_BYTE))
    else $error("option byte not copied");
  chk_lock_decode: assert property (@(posedge CLK_SYS) disable iff (RST)
    !opened |-> (LOCKED == (working_option_reg[1:0] != LOCK_OPEN)))
    else $error("lock decode wrong");
  chk_open_unlocked: assert property (@(posedge CLK_SYS) disable iff (RST)
    opened |-> !LOCKED)
    else $error("opened but still locked");
  chk_debug_locked: assert property (@(posedge CLK_SYS) disable iff (RST)
    LOCKED |-> !DEBUG_ENABLE_OK)
    else $error("debug enabled while locked");
  chk_key_source: assert property (@(posedge CLK_SYS) disable iff (RST)
    KEY_CAPTURE |-> (ACC.src == SRC_SECURE && backdoor_allow))
    else $error("key captured from wrong source");
  chk_ratio_once: assert property (@(posedge CLK_SYS) disable iff (RST)
    ($past(ratio_loaded_flag) && opt_taken) |-> $stable(nvm_clock_ratio))
    else $error("ratio changed after first write");
  chk_unloaded_no_pe: assert property (@(posedge CLK_SYS) disable iff (RST)
    !ratio_loaded_flag |-> (!PE_ENABLE && !CMD_START && !NVM_PULSE))
    else $error("program allowed before ratio loaded");
  chk_open_sticky: assert property (@(posedge CLK_SYS) disable iff (RST)
    BLANK_OK |=> !LOCKED [*2])
    else $error("blank check did not unlock");
  chk_erase_extent: assert property (@(posedge CLK_SYS) disable iff (RST)
    (ERASE_REQ && !eeprom_sector_layout) |-> EE_ERASE_PAGES == 2'b11)
    else $error("split erase not both pages");
  chk_whole_erase: assert property (@(posedge CLK_SYS) disable iff (RST)
    (ERASE_REQ && eeprom_sector_layout) |-> ($onehot(EE_ERASE_PAGES) && EE_ERASE_PAGES[eeprom_half_select]))
    else $error("whole erase not foreground page");
  chk_key_no_cmd: assert property (@(posedge CLK_SYS) disable iff (RST)
    KEY_CAPTURE |-> !CMD_START)
    else $error("key write started a command");
  chk_prot_debug_only: assert property (@(posedge CLK_SYS) disable iff (RST)
    (opt_taken && ph_wr && ph_addr == ADDR_PROTECTION && ACC.src != SRC_DEBUG) |=> $stable(protection_reg))
    else $error("protection changed by software");
  // Key range sits inside the vector block, so its protection covers the key
  chk_key_in_vectors: assert property (@(posedge CLK_SYS) disable iff (RST)
    (ACC.valid && is_key_addr) |-> (ACC.addr >= VECTOR_BLOCK_BASE))
    else $error("key range outside vector block");
endmodule
`default_nettype wire

// ### nlk_core_model.sv
// Core and debug side model issuing memory accesses to the lock gate
`timescale 1ns/100ps
`default_nettype none
module nlk_core_model (
  input  wire logic              clk,       // Bus clock
  output var nlk_pkg::nlk_acc_t  acc,       // Access toward the gate
  output var logic [7:0]         mem_rdata  // Raw memory data
);
  import nlk_pkg::*;
  // Idle bus at time zero
  initial
  begin
    acc = '0;
    mem_rdata = 8'h3c;
  end
  // Present one access; the caller samples the gate on return
  task put(input logic w, input logic [15:0] a, input logic [7:0] d, input nlk_src_t s);
    @(posedge clk);
    acc <= '{1'b1, w, a, d, s == SRC_SECURE, s};
    mem_rdata <= 8'ha5;
    #1;
  endtask
  // Release, then one idle cycle so accesses never sit adjacent
  task rest();
    @(posedge clk);
    acc.valid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    @(posedge clk);
    mem_rdata <= ~mem_rdata;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the lock gate, key unlock, page map and divider
`timescale 1ns/100ps
`default_nettype none
module tb;
  import nlk_pkg::*;
  logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, background_pin_pin, blank_ok, erase_req;
  logic [7:0]  haddr, opt_byte, mem_rdata;
  logic [1:0]  htrans, ee_erase_pages;
  logic [31:0] hwdata, hrdata, rd;
  logic        ee_page, key_capture, cmd_start, locked, dbg_ok, bgnd_active, pe_enable, nvm_pulse;
  nlk_acc_t    acc;
  nlk_gate_t   gate;
  int          fail_count, tests_run;
  localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
  nlk_top #(.CLK_NS(50)) nlk_top_i (
    .CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .OPT_BYTE(opt_byte), .PROT_BYTE(8'h5a),
    .KEY_PHRASE(KEY), .BACKGROUND_PIN_PIN(background_pin_pin), .ACC(acc), .MEM_RDATA(mem_rdata),
    .BLANK_OK(blank_ok), .ERASE_REQ(erase_req), .GATE(gate), .EE_PAGE(ee_page),
    .EE_ERASE_PAGES(ee_erase_pages), .KEY_CAPTURE(key_capture), .CMD_START(cmd_start),
    .LOCKED(locked), .DEBUG_ENABLE_OK(dbg_ok), .BGND_ACTIVE(bgnd_active),
    .PE_ENABLE(pe_enable), .NVM_PULSE(nvm_pulse));
  nlk_core_model nlk_core_model_i (.clk(clk_sys), .acc(acc), .mem_rdata(mem_rdata));
  // Bus clock, 50 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Compare one value and count it
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts, verdict and end of run
  task print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Wait for ready at a rising edge, bounded
  task wait_rdy();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        fail_count++;
        print_verdict();
      end
      @(posedge clk_sys);
    end
  endtask
  // One single AHB-Lite word transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("response", 32'h0, 32'(hresp));
  endtask
  // Reset held 12 cycles with a given option byte and pin level
  task rst_dut(input logic [7:0] opt, input logic bk);
    @(posedge clk_sys);
    rst <= 1'b1;
    opt_byte <= opt;
    background_pin_pin <= bk;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // Every lock code, with the pin low on the even codes
  task test_codes();
    for (int c = 0; c < 4; c++)
    begin
      rst_dut({6'h20, 2'(c)}, c[0]);
      chk("locked", 32'(c != 2), 32'(locked));
      chk("debug ok", 32'(c == 2), 32'(dbg_ok));
      chk("background", 32'(!c[0]), 32'(bgnd_active));
      ahb(1'b0, ADDR_OPTION, 32'h0);
      chk("option", {24'h0, 6'h20, 2'(c)}, rd);
    end
    $display("lock code test done");
  endtask
  // Gate while locked, then blank check unlock
  task test_gate();
    rst_dut(8'h03, 1'b1);
    nlk_core_model_i.put(1'b0, 16'h1000, 8'h00, SRC_UNSECURE);
    chk("gate unsecure", 32'h0, 32'(gate));
    nlk_core_model_i.rest();
    nlk_core_model_i.put(1'b1, 16'h1000, 8'h77, SRC_DEBUG);
    chk("gate debug allow", 32'h0, 32'(gate.allow));
    nlk_core_model_i.rest();
    nlk_core_model_i.put(1'b0, 16'h1000, 8'h00, SRC_SECURE);
    chk("gate secure", 32'h1a5, 32'(gate));
    nlk_core_model_i.rest();
    ahb(1'b1, ADDR_PROTECTION, 32'ha5);
    ahb(1'b0, ADDR_PROTECTION, 32'h0);
    chk("protection", 32'h5a, rd);
    nlk_core_model_i.put(1'b0, 16'h1000, 8'h00, SRC_DEBUG);
    nlk_core_model_i.rest();
    ahb(1'b1, ADDR_PROTECTION, 32'h33);
    ahb(1'b0, ADDR_PROTECTION, 32'h0);
    chk("protection debug", 32'h33, rd);
    ahb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    @(posedge clk_sys);
    blank_ok <= 1'b1;
    @(posedge clk_sys);
    blank_ok <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("locked after blank", 32'h0, 32'(locked));
    nlk_core_model_i.put(1'b0, 16'h1000, 8'h00, SRC_UNSECURE);
    chk("gate open", 32'h1a5, 32'(gate));
    nlk_core_model_i.rest();
    $display("gate test done");
  endtask
  // Write-once divider and pulse spacing
  task test_ratio(input logic [7:0] v, input int period);
    int n;
    rst_dut(8'h02, 1'b1);
    chk("pe before", 32'h0, 32'(pe_enable));
    ahb(1'b0, ADDR_CLOCK_RATIO, 32'h0);
    chk("ratio reset", 32'h0, rd);
    ahb(1'b1, ADDR_CLOCK_RATIO, {24'h0, v});
    ahb(1'b1, ADDR_CLOCK_RATIO, 32'h0);
    ahb(1'b0, ADDR_CLOCK_RATIO, 32'h0);
    chk("ratio", {24'h0, 1'b1, v[6:0]}, rd);
    chk("pe after", 32'h1, 32'(pe_enable));
    nlk_core_model_i.put(1'b1, KEY_BASE, 8'h11, SRC_SECURE);
    chk("command start", 32'h1, 32'(cmd_start));
    nlk_core_model_i.rest();
    n = 0;
    do @(posedge clk_sys); while (nvm_pulse !== 1'b1 && ++n < 300);
    @(posedge clk_sys);
    chk("pulse width", 32'h0, 32'(nvm_pulse));
    n = 1;
    while (nvm_pulse !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("pulse period", 32'(period), 32'(n));
    $display("ratio test done");
  endtask
  // Backdoor key entry with source, corruption and expected lock
  task try_key(input logic [7:0] opt, input nlk_src_t s, input logic [7:0] flip, input logic exp);
    rst_dut(opt, 1'b1);
    ahb(1'b1, ADDR_CLOCK_RATIO, 32'h4c);
    ahb(1'b1, ADDR_CONFIG, 32'h20);
    for (int i = 0; i < KEY_BYTES; i++)
    begin
      nlk_core_model_i.put(1'b1, KEY_BASE + 16'(i), KEY[8*i +: 8] ^ flip, s);
      chk("key capture", 32'(s == SRC_SECURE && opt[7]), 32'(key_capture));
      if (s == SRC_SECURE)
        chk("no command", 32'h0, 32'(cmd_start));
      nlk_core_model_i.rest();
    end
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk("key count", (s == SRC_SECURE && opt[7]) ? 32'(KEY_BYTES) : 32'h0, rd);
    ahb(1'b1, ADDR_CONFIG, 32'h0);
    repeat (3) @(posedge clk_sys);
    #1 chk("locked after key", 32'(exp), 32'(locked));
    $display("key test done");
  endtask
  // Page select and erase reach in both sector layouts
  task test_eeprom();
    for (int k = 0; k < 4; k++)
    begin
      rst_dut({2'h0, k[1], 5'h02}, 1'b1);
      ahb(1'b1, ADDR_CONFIG, {25'h0, k[0], 6'h0});
      erase_req <= 1'b1;
      @(posedge clk_sys);
      chk("page", 32'(k[0]), 32'(ee_page));
      chk("erase pages", k[1] ? (k[0] ? 32'h2 : 32'h1) : 32'h3, 32'(ee_erase_pages));
      erase_req <= 1'b0;
    end
    $display("eeprom test done");
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    opt_byte = 8'h03;
    background_pin_pin = 1'b1;
    blank_ok = 1'b0;
    erase_req = 1'b0;
    fail_count = 0;
    tests_run = 0;
    test_codes();
    test_gate();
    test_ratio(8'h4c, 104);
    test_ratio(8'h03, 4);
    try_key(8'h83, SRC_SECURE, 8'h00, 1'b0);
    try_key(8'h83, SRC_SECURE, 8'h01, 1'b1);
    try_key(8'h83, SRC_DEBUG, 8'h00, 1'b1);
    try_key(8'h03, SRC_SECURE, 8'h00, 1'b1);
    test_eeprom();
    print_verdict();
  end
endmodule
`default_nettype wire
